// ===== design/uwf_pkg.sv
package uwf_pkg;

  // ****************************************
  // serial frame: 8-bit command then 32-bit word, msb first
  // ****************************************
  localparam int FRAME_BITS = 40;
  localparam logic [5:0] CMD_LAST = 6'h07;
  localparam logic [5:0] FRAME_LAST = 6'h27;
  localparam int CMD_WR_BIT = 7;
  localparam logic [5:0] IDX_PIN_CTRL = 6'h00;
  localparam logic [5:0] IDX_RADIO = 6'h01;

  // ****************************************
  // pin_control_reg layout
  // ****************************************
  localparam int PIN_DIR_LSB = 0;
  localparam int PIN_OUT_LSB = 3;
  localparam int PIN_LVL_LSB = 10;
  localparam int AMP_MODE_LSB = 14;
  localparam logic [1:0] MODE_ALT = 2'h1;
  localparam logic [31:0] PIN_CTRL_RST = 32'h0000_0000;
  localparam int PIN_AMP = 0;
  localparam int PIN_TX = 1;
  localparam int PIN_RX = 2;

  // ****************************************
  // radio control word
  // ****************************************
  localparam int RAD_SEND_BIT = 0;
  localparam int RAD_AUTORX_BIT = 1;
  localparam int RAD_RX_BIT = 2;
  localparam int RAD_STOP_BIT = 3;
  localparam int RAD_FINE_BIT = 4;
  localparam logic FINE_SEQ_RST = 1'b1;
  localparam logic [7:0] TX_LEN_CYC = 8'h40;

  // ****************************************
  // host controller
  // ****************************************
  localparam logic [4:0] SCK_HALF_CYC = 5'h10;
  localparam logic [3:0] STRAP_HOLD_CYC = 4'h8;
  localparam logic [6:0] EDGE_LAST = 7'h4f;
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_WDATA = 8'h04;
  localparam logic [7:0] A_RDATA = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_CFG = 8'h10;
  localparam int CFG_RST_BIT = 0;
  localparam int CFG_POL_BIT = 1;
  localparam int CFG_PHA_BIT = 2;
  localparam logic [2:0] CFG_RST = 3'h0;

  typedef enum logic [2:0] {
    RAD_IDLE = 3'b001,
    RAD_TX = 3'b010,
    RAD_RX = 3'b100
  } uwf_radio_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LEAD = 4'b0010,
    H_XFER = 4'b0100,
    H_TAIL = 4'b1000
  } uwf_host_st_t;

  function automatic logic fn_alt(input logic [31:0] ctrl, input int pin);
    fn_alt = (ctrl[AMP_MODE_LSB + 2 * pin +: 2] == MODE_ALT);
  endfunction

endpackage

// ===== design/uwf_link_if.sv
`timescale 1ns/1ps
interface uwf_link_if;
  logic active_low_reset_pin;
  logic sclk;
  logic serial_select_n;
  logic mosi;
  logic dev_miso;
  logic dev_miso_oe_n;
  logic miso;
  logic [2:0] dev_pin_o;
  logic [2:0] dev_pin_oe_n;
  logic [2:0] dev_pull_en;
  logic [2:0] host_pin_o;
  logic [2:0] host_pin_oe_n;
  logic amp_ctrl_pin;
  logic pol_strap_tx_pin;
  logic pha_strap_rx_pin;

  // undriven pins settle low: the internal pulldowns, or a parked shared line
  function automatic logic res(input logic d_oe_n, input logic d_o, input logic h_oe_n, input logic h_o);
    res = !d_oe_n ? d_o : (!h_oe_n ? h_o : 1'b0);
  endfunction

  assign miso = dev_miso_oe_n ? 1'b0 : dev_miso;
  assign amp_ctrl_pin = res(dev_pin_oe_n[0], dev_pin_o[0], host_pin_oe_n[0], host_pin_o[0]);
  assign pol_strap_tx_pin = res(dev_pin_oe_n[1], dev_pin_o[1], host_pin_oe_n[1], host_pin_o[1]);
  assign pha_strap_rx_pin = res(dev_pin_oe_n[2], dev_pin_o[2], host_pin_oe_n[2], host_pin_o[2]);

  modport dev (
    input active_low_reset_pin,
    input sclk,
    input serial_select_n,
    input mosi,
    input amp_ctrl_pin,
    input pol_strap_tx_pin,
    input pha_strap_rx_pin,
    output dev_miso,
    output dev_miso_oe_n,
    output dev_pin_o,
    output dev_pin_oe_n,
    output dev_pull_en
  );

  modport host (
    output active_low_reset_pin,
    output sclk,
    output serial_select_n,
    output mosi,
    output host_pin_o,
    output host_pin_oe_n,
    input miso,
    input amp_ctrl_pin,
    input pol_strap_tx_pin,
    input pha_strap_rx_pin
  );
endinterface

// ===== design/uwf_sync.sv
`timescale 1ns/1ps
module uwf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } uwf_sync_st_t;

  uwf_sync_st_t r;
  uwf_sync_st_t n;

  // a bit moves only when stages two and three agree
  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.q;
endmodule

// ===== design/uwf_dev.sv
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - straps pick serial mode zero to three
// - modes 0/3: host samples rising edge
// - modes 1/2: host samples falling edge
// - straps latched at reset rise, kept
// - strap pins pulled low internally
// - strap pins become gpio or alternate
// - receive enable high while receiving
// - transmit enable high while transmitting
// - third pin drives amplifier enable
// - both enables low: front end idle
// - receive enable only: low-noise amplifier on
// - transmit only; never both enables high
// - data output released when not selected
// - amplifier on for sends; receive after poll
// - host sets mode masks in pin register
// - host disables fine sequencing for amplifier
module uwf_dev
  import uwf_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  uwf_link_if.dev LINK,
  output logic [1:0] SPI_MODE,
  output logic TX_ON,
  output logic RX_ON
);

  typedef struct packed {
    logic [31:0] pin_ctrl;
    logic fine_seq;
    uwf_radio_t radio;
    logic [7:0] tx_cnt;
    logic auto_rx;
    logic [1:0] mode;
    logic rst_seen;
    logic sck_prev;
    logic cs_prev;
    logic [5:0] bit_cnt;
    logic [7:0] cmd;
    logic [31:0] rx_sh;
    logic [31:0] tx_sh;
    logic miso;
    logic miso_oe_n;
    logic [2:0] pin_o;
    logic [2:0] pin_oe_n;
    logic [2:0] pull_en;
  } uwf_dev_st_t;

  uwf_dev_st_t r;
  uwf_dev_st_t n;
  logic [6:0] q;
  logic rst_ok;
  logic cs_lo;
  logic sck;
  logic mosi;
  logic [2:0] lvl;
  logic moved;
  logic lead;
  logic trail;
  logic smp;
  logic lch;
  logic [31:0] wdat;
  logic [31:0] rd_word;
  logic wr_go;
  logic go_send;
  logic go_rx;
  logic go_stop;
  logic [2:0] fn;
  logic alt;

  // ****************************************
  // pin inputs
  // ****************************************
  uwf_sync #(.W(7)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d({LINK.active_low_reset_pin, LINK.serial_select_n, LINK.sclk, LINK.mosi,
        LINK.pha_strap_rx_pin, LINK.pol_strap_tx_pin, LINK.amp_ctrl_pin}),
    .q(q)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    rst_ok = q[6];
    cs_lo = ~q[5];
    sck = q[4];
    mosi = q[3];
    lvl = q[2:0];
    moved = (sck != r.sck_prev);
    // leading edge leaves the idle level, which is the polarity strap
    lead = moved & (sck != r.mode[1]) & cs_lo;
    trail = moved & (sck == r.mode[1]) & cs_lo;
    // phase 0 samples on the leading edge, phase 1 on the trailing
    smp = r.mode[0] ? trail : lead;
    lch = r.mode[0] ? lead : trail;
    wdat = {r.rx_sh[30:0], mosi};
    wr_go = 1'b0;
    go_send = 1'b0;
    go_rx = 1'b0;
    go_stop = 1'b0;
    fn = 3'h0;
    alt = 1'b0;
    n.sck_prev = sck;
    n.cs_prev = cs_lo;
    n.rst_seen = rst_ok;

    rd_word = 32'h0;
    unique case (wdat[5:0])
      IDX_PIN_CTRL: begin
        rd_word = r.pin_ctrl;
        rd_word[PIN_LVL_LSB +: 3] = lvl;
      end
      IDX_RADIO: begin
        rd_word = {27'h0, r.fine_seq, r.mode, r.radio[2], r.radio[1]};
      end
      default: begin
        rd_word = 32'h0;
      end
    endcase

    // serial slave
    if (!r.cs_prev && cs_lo) begin
      n.bit_cnt = 6'h0;
      n.tx_sh = 32'h0;
      n.miso = 1'b0;
      n.miso_oe_n = 1'b0;
    end else if (smp) begin
      n.rx_sh = wdat;
      if (r.bit_cnt <= FRAME_LAST) begin
        n.bit_cnt = r.bit_cnt + 6'h1;
      end
      if (r.bit_cnt == CMD_LAST) begin
        n.cmd = wdat[7:0];
        n.tx_sh = rd_word;
      end
      if (r.bit_cnt == FRAME_LAST && r.cmd[CMD_WR_BIT]) begin
        wr_go = 1'b1;
      end
    end else if (lch) begin
      n.miso = r.tx_sh[31];
      n.tx_sh = {r.tx_sh[30:0], 1'b0};
    end
    if (!cs_lo) begin
      n.miso_oe_n = 1'b1;
    end

    // register writes
    if (wr_go) begin
      if (r.cmd[5:0] == IDX_PIN_CTRL) begin
        n.pin_ctrl = wdat;
      end else if (r.cmd[5:0] == IDX_RADIO) begin
        go_send = wdat[RAD_SEND_BIT];
        go_rx = wdat[RAD_RX_BIT];
        go_stop = wdat[RAD_STOP_BIT];
        n.fine_seq = wdat[RAD_FINE_BIT];
        if (wdat[RAD_SEND_BIT]) begin
          n.auto_rx = wdat[RAD_AUTORX_BIT];
        end
      end
    end

    // radio sequencing; one-hot state keeps transmit and receive exclusive
    unique case (r.radio)
      RAD_IDLE: begin
        if (go_send) begin
          n.radio = RAD_TX;
          n.tx_cnt = TX_LEN_CYC;
        end else if (go_rx) begin
          n.radio = RAD_RX;
        end
      end
      RAD_TX: begin
        n.tx_cnt = r.tx_cnt - 8'h1;
        if (go_stop) begin
          n.radio = RAD_IDLE;
        end else if (r.tx_cnt == 8'h1) begin
          // a poll goes straight to listening for the answer
          n.radio = r.auto_rx ? RAD_RX : RAD_IDLE;
        end
      end
      RAD_RX: begin
        if (go_stop) begin
          n.radio = RAD_IDLE;
        end else if (go_send) begin
          n.radio = RAD_TX;
          n.tx_cnt = TX_LEN_CYC;
        end
      end
      default: begin
        n.radio = RAD_IDLE;
      end
    endcase

    // reset pin low returns the pin and radio registers to their reset values and clears frame count and data drive; the captured mode is kept
    if (!rst_ok) begin
      n.pin_ctrl = PIN_CTRL_RST;
      n.fine_seq = FINE_SEQ_RST;
      n.radio = RAD_IDLE;
      n.tx_cnt = 8'h0;
      n.bit_cnt = 6'h0;
      n.miso_oe_n = 1'b1;
    end
    if (rst_ok && !r.rst_seen) begin
      n.mode = {lvl[PIN_TX], lvl[PIN_RX]};
    end

    // pin drive; amplifier follows transmit only with fine sequencing off
    fn[PIN_AMP] = n.radio[1] & ~n.fine_seq;
    fn[PIN_TX] = n.radio[1];
    fn[PIN_RX] = n.radio[2];
    for (int p = 0; p < 3; p++) begin
      alt = fn_alt(n.pin_ctrl, p) & rst_ok;
      if (alt) begin
        n.pin_oe_n[p] = 1'b0;
        n.pin_o[p] = fn[p];
      end else if (n.pin_ctrl[PIN_DIR_LSB + p] && rst_ok) begin
        n.pin_oe_n[p] = 1'b0;
        n.pin_o[p] = n.pin_ctrl[PIN_OUT_LSB + p];
      end else begin
        n.pin_oe_n[p] = 1'b1;
        n.pin_o[p] = 1'b0;
      end
      n.pull_en[p] = n.pin_oe_n[p];
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '{pin_ctrl: PIN_CTRL_RST, fine_seq: FINE_SEQ_RST, radio: RAD_IDLE,
             miso_oe_n: 1'b1, pin_oe_n: 3'h7, pull_en: 3'h7, cs_prev: 1'b0, default: '0};
    end else begin
      r <= n;
    end
  end

  assign LINK.dev_miso = r.miso;
  assign LINK.dev_miso_oe_n = r.miso_oe_n;
  assign LINK.dev_pin_o = r.pin_o;
  assign LINK.dev_pin_oe_n = r.pin_oe_n;
  assign LINK.dev_pull_en = r.pull_en;
  assign SPI_MODE = r.mode;
  assign TX_ON = r.radio[1];
  assign RX_ON = r.radio[2];
endmodule

// ===== design/uwf_host.sv
`timescale 1ns/1ps
module uwf_host
  import uwf_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  uwf_link_if.host LINK
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] cfg;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [7:0] cmd;
    logic done;
    uwf_host_st_t st;
    logic [4:0] div;
    logic [6:0] edges;
    logic [39:0] tx_sh;
    logic [31:0] rx_sh;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [3:0] hold;
    logic rst_pin_n;
    logic [1:0] strap_oe_n;
  } uwf_host_st_s_t;

  uwf_host_st_s_t r;
  uwf_host_st_s_t n;
  logic miso_s;
  logic tick;
  logic wr;
  logic new_sck;
  logic strap_on;

  uwf_sync #(.W(1)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(LINK.miso),
    .q(miso_s)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    tick = (r.div == 5'h0);
    wr = PSEL & PENABLE & PWRITE;
    new_sck = ~r.sclk;
    n.pready = 1'b1;
    n.div = tick ? 5'h0 : r.div - 5'h1;

    // apb: answer prepared in setup, zero wait states
    if (PSEL && !PENABLE) begin
      n.pslverr = 1'b0;
      unique case (PADDR)
        A_CMD: n.prdata = {24'h0, r.cmd};
        A_WDATA: n.prdata = r.wdata;
        A_RDATA: n.prdata = r.rdata;
        A_STAT: n.prdata = {30'h0, r.done, (r.st != H_IDLE)};
        A_CFG: n.prdata = {29'h0, r.cfg};
        default: begin
          n.prdata = 32'h0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (wr && PADDR == A_WDATA) begin
      n.wdata = PWDATA;
    end
    // config is only taken while idle so the clock never glitches mid-frame
    if (wr && PADDR == A_CFG && r.st == H_IDLE) begin
      n.cfg = PWDATA[2:0];
      n.sclk = PWDATA[CFG_POL_BIT];
      if (r.cfg[CFG_RST_BIT] && !PWDATA[CFG_RST_BIT]) begin
        n.hold = STRAP_HOLD_CYC;
      end
    end else if (r.hold != 4'h0) begin
      n.hold = r.hold - 4'h1;
    end

    unique case (r.st)
      H_IDLE: begin
        // div still counting means chip select has not been high long enough
        if (wr && PADDR == A_CMD && tick) begin
          n.cmd = PWDATA[7:0];
          n.done = 1'b0;
          n.cs_n = 1'b0;
          n.tx_sh = {PWDATA[7:0], r.wdata};
          n.div = SCK_HALF_CYC - 5'h1;
          n.edges = 7'h0;
          n.st = H_LEAD;
          if (!r.cfg[CFG_PHA_BIT]) begin
            n.mosi = PWDATA[7];
            n.tx_sh = {PWDATA[6:0], r.wdata, 1'b0};
          end
        end
      end
      H_LEAD: begin
        if (tick) begin
          n.div = SCK_HALF_CYC - 5'h1;
          n.st = H_XFER;
        end
      end
      H_XFER: begin
        if (tick) begin
          n.div = SCK_HALF_CYC - 5'h1;
          n.sclk = new_sck;
          n.edges = r.edges + 7'h1;
          // rising samples in modes 0 and 3, falling in modes 1 and 2
          if (new_sck == ~(r.cfg[CFG_POL_BIT] ^ r.cfg[CFG_PHA_BIT])) begin
            n.rx_sh = {r.rx_sh[30:0], miso_s};
          end else begin
            n.mosi = r.tx_sh[39];
            n.tx_sh = {r.tx_sh[38:0], 1'b0};
          end
          if (r.edges == EDGE_LAST) begin
            n.st = H_TAIL;
          end
        end
      end
      H_TAIL: begin
        if (tick) begin
          n.div = SCK_HALF_CYC - 5'h1;
          n.cs_n = 1'b1;
          n.done = 1'b1;
          n.rdata = r.rx_sh;
          n.st = H_IDLE;
        end
      end
      default: begin
        n.st = H_IDLE;
      end
    endcase
    strap_on = n.cfg[CFG_RST_BIT] | (n.hold != 4'h0);
    n.rst_pin_n = ~n.cfg[CFG_RST_BIT];
    // straps are only driven around the reset pulse, then released to the device
    n.strap_oe_n = ~({n.cfg[CFG_PHA_BIT], n.cfg[CFG_POL_BIT]} & {2{strap_on}});
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '{cfg: CFG_RST, st: H_IDLE, cs_n: 1'b1, rst_pin_n: 1'b1, strap_oe_n: 2'h3, default: '0};
    end else begin
      r <= n;
    end
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign LINK.active_low_reset_pin = r.rst_pin_n;
  assign LINK.sclk = r.sclk;
  assign LINK.serial_select_n = r.cs_n;
  assign LINK.mosi = r.mosi;
  assign LINK.host_pin_o = 3'h6;
  assign LINK.host_pin_oe_n = {r.strap_oe_n, 1'b1};
endmodule

// ===== tb/uwf_props.sv
`timescale 1ns/1ps
module uwf_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic active_low_reset_pin,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic dev_miso_oe_n,
  input wire logic [2:0] dev_pin_o,
  input wire logic [2:0] dev_pin_oe_n,
  input wire logic [2:0] dev_pull_en
);
  logic sclk_r;
  logic [7:0] tog_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ****************************************
  // sclk toggles counted per select window
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_r <= 1'b0;
      tog_r <= 8'h00;
    end else begin
      sclk_r <= sclk;
      if (serial_select_n) begin
        tog_r <= 8'h00;
      end else if (sclk != sclk_r) begin
        tog_r <= tog_r + 8'h01;
      end
    end
  end

  sequence s_quiet;
    $stable(sclk) [*8];
  endsequence

  sequence s_selected;
    $fell(serial_select_n) ##0 active_low_reset_pin ##1 !serial_select_n [*8];
  endsequence

  a_pins_in_rst: assert property (!active_low_reset_pin [*6] |-> dev_pin_oe_n == 3'h7)
    else $error("pin driven while device reset is low");
  a_pull_on_input: assert property ((dev_pin_oe_n & ~dev_pull_en) == 3'h0)
    else $error("undriven pin without pulldown");
  a_no_both_en: assert property (!(!dev_pin_oe_n[1] && dev_pin_o[1] && !dev_pin_oe_n[2] && dev_pin_o[2]))
    else $error("transmit and receive enables both driven high");
  a_miso_release: assert property (serial_select_n [*8] |-> dev_miso_oe_n)
    else $error("data output driven while not selected");
  a_miso_drive: assert property (s_selected |-> !dev_miso_oe_n)
    else $error("data output not driven while selected");
  a_sclk_half: assert property ($changed(sclk) |=> s_quiet)
    else $error("serial clock half period too short");
  a_sclk_lead: assert property ($fell(serial_select_n) |-> s_quiet)
    else $error("serial clock moved too soon after select");
  a_frame_toggles: assert property ($rose(serial_select_n) |-> tog_r == 8'h50)
    else $error("frame did not carry 80 clock edges");
endmodule

// ===== tb/tb_spi_strap_and_rf_frontend_ctrl.sv
`timescale 1ns/1ps
module tb_spi_strap_and_rf_frontend_ctrl import uwf_pkg::*;;
  logic clk;
  logic rst_n;
  logic psel, penable, pwrite, pready, pslverr, ok, err, tx_on, rx_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] spi_mode;
  int n_mismatch = 0;
  int compares = 0;

  uwf_link_if link();
  uwf_dev u_uwf_dev (.CLK(clk), .RST_N(rst_n), .LINK(link.dev), .SPI_MODE(spi_mode), .TX_ON(tx_on),
    .RX_ON(rx_on));
  uwf_host u_uwf_host (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link.host));
  uwf_props u_uwf_props (.CLK(clk), .RST_N(rst_n), .active_low_reset_pin(link.active_low_reset_pin),
    .sclk(link.sclk), .serial_select_n(link.serial_select_n), .dev_miso_oe_n(link.dev_miso_oe_n),
    .dev_pin_o(link.dev_pin_o), .dev_pin_oe_n(link.dev_pin_oe_n), .dev_pull_en(link.dev_pull_en));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task summarize;
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // the answer is taken at the same rising edge that sees pready high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      {ok, err, rd} = {pready, pslverr, prdata};
      if (ok === 1'b1) break;
    end
    chk("apb ready", 32'h1, 32'(ok));
    if (ok !== 1'b1) summarize;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // the gap keeps clear of the window in which a new command is ignored
  task frame(input logic [7:0] cmd, input logic [31:0] wd);
    int i;
    repeat (20) @(posedge clk);
    apb(1'b1, A_WDATA, wd);
    apb(1'b1, A_CMD, {24'h0, cmd});
    i = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      i++;
    end while (rd[1] !== 1'b1 && i < 1000);
    chk("frame done", 32'h1, 32'(rd[1]));
    if (rd[1] !== 1'b1) summarize;
    apb(1'b0, A_RDATA, 32'h0);
  endtask

  task watch_tx(input logic amp_exp, input logic rx_after);
    int n;
    for (n = 0; n < 4000 && tx_on !== 1'b1; n++) @(negedge clk);
    chk("tx start", 32'h1, 32'(tx_on));
    if (tx_on !== 1'b1) summarize;
    for (n = 0; n < 300 && tx_on === 1'b1; n++) begin
      @(negedge clk);
      if (n == 2) begin
        chk("tx pins", {30'h0, 1'b1, amp_exp}, 32'({link.pha_strap_rx_pin, link.pol_strap_tx_pin,
          link.amp_ctrl_pin}));
      end
    end
    chk("tx length", {24'h0, TX_LEN_CYC}, n[31:0]);
    if (tx_on === 1'b1) summarize;
    repeat (2) @(negedge clk);
    chk("after tx", {29'h0, rx_after, rx_after, 1'b0}, 32'({rx_on, link.pha_strap_rx_pin,
      link.pol_strap_tx_pin | link.amp_ctrl_pin}));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_defaults;
    frame({2'b00, IDX_PIN_CTRL}, 32'h0);
    chk("pin ctrl", PIN_CTRL_RST, rd);
    chk("mode", 32'h0, 32'(spi_mode));
    chk("pins input", 32'h3f, 32'({link.dev_pin_oe_n, link.dev_pull_en}));
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
  endtask

  task t_gpio;
    frame({2'b10, IDX_PIN_CTRL}, 32'h0000_0009);
    chk("gpio drive", 32'hd, 32'({link.dev_pin_oe_n, link.amp_ctrl_pin}));
  endtask

  task t_front;
    frame({2'b10, IDX_PIN_CTRL}, PIN_CTRL_RST | 32'h0001_4000 | 32'h0005_0000);
    frame({2'b10, IDX_RADIO}, 32'h0);
    chk("idle", 32'h0, 32'({link.amp_ctrl_pin, link.pol_strap_tx_pin, link.pha_strap_rx_pin}));
    fork
      frame({2'b10, IDX_RADIO}, 32'h3);
      watch_tx(1'b1, 1'b1);
    join
    frame({2'b00, IDX_PIN_CTRL}, 32'h0);
    chk("levels", 32'h154, 32'(rd[19:10]));
    frame({2'b10, IDX_RADIO}, 32'h8);
    chk("stopped", 32'h0, 32'({rx_on, link.pol_strap_tx_pin, link.pha_strap_rx_pin}));
    frame({2'b10, IDX_RADIO}, 32'h4);
    chk("rx only", 32'h6, 32'({rx_on, link.pha_strap_rx_pin, link.pol_strap_tx_pin}));
    fork
      frame({2'b10, IDX_RADIO}, 32'h11);
      watch_tx(1'b0, 1'b0);
    join
  endtask

  // mode 0 comes last so the run ends in the default mode
  task t_modes;
    logic [1:0] m;
    int k;
    for (k = 1; k < 5; k++) begin
      m = 2'(k);
      apb(1'b1, A_CFG, {29'h0, m[0], m[1], 1'b1});
      repeat (20) @(posedge clk);
      chk("pins in reset", 32'h7, 32'(link.dev_pin_oe_n));
      apb(1'b1, A_CFG, {29'h0, m[0], m[1], 1'b0});
      repeat (40) @(posedge clk);
      chk("mode", 32'(m), 32'(spi_mode));
      frame({2'b10, IDX_PIN_CTRL}, 32'h38);
      frame({2'b00, IDX_PIN_CTRL}, 32'h0);
      chk("readback", 32'h38, rd & 32'h3f);
      chk("mode kept", 32'(m), 32'(spi_mode));
      frame({2'b00, IDX_RADIO}, 32'h0);
      chk("radio word", {27'h0, FINE_SEQ_RST, m, 2'b00}, rd);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, ok, err} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rd = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_defaults;
    t_gpio;
    t_front;
    t_modes;
    summarize;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    summarize;
  end
endmodule
